// *** serial_eeprom_pkg.sv ***
// shared constants and state codes for the serial memory slave
package serial_eeprom_pkg;
    localparam int          CLK_PERIOD_NS       = 100;      // core clock period
    localparam int          WRITE_CYCLE_TIME_NS = 5000000;  // self-timed write, longest
    // longest time, so round down to whole core cycles
    localparam int          WRITE_CYCLES        = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  TYPE_ID_DEFAULT     = 4'h5;     // arbitrary value
    localparam logic [2:0]  CHIP_ENABLE         = 3'h0;     // chip-enable field
    localparam int          PAGE_BITS           = 6;        // bytes per row, log2
    localparam int          ADDR_BITS_DEFAULT   = 15;       // larger variant
    localparam logic [3:0]  CNT_ZERO            = 4'h0;     // first bit of a byte
    localparam logic [3:0]  CNT_ONE             = 4'h1;     // bit count step
    localparam logic [3:0]  BYTE_DONE           = 4'h8;     // eight bits moved
    localparam logic [3:0]  ACK_SLOT            = 4'h9;     // ninth bit slot
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,  // standby, waiting for start
        ST_SELECT  = 3'h1,  // receiving select byte
        ST_ADDR_HI = 3'h2,  // receiving high address byte
        ST_ADDR_LO = 3'h3,  // receiving low address byte
        ST_WDATA   = 3'h4,  // receiving data bytes
        ST_RDATA   = 3'h5,  // sending data bytes
        ST_HOLD    = 3'h6   // released, waiting for start or stop
    } bus_state_type;
endpackage

// *** serial_eeprom_i2c_slave.sv ***
// two-wire serial memory slave: bus engine, page latch, array and write timer
`timescale 1ns/1ps
module serial_eeprom_i2c_slave
    import serial_eeprom_pkg::*;
#(
    parameter int         ADDR_BITS         = ADDR_BITS_DEFAULT,
    parameter logic [3:0] TYPE_ID           = TYPE_ID_DEFAULT,
    parameter int         WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic link_clk,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic write_inhibit_n,
    output logic      write_busy
);
    localparam int DEPTH = 1 << ADDR_BITS;  // bytes in the array
    localparam int PAGE  = 1 << PAGE_BITS;  // bytes in one row

    // refuse variants the address logic cannot serve
    if (ADDR_BITS < 14 || ADDR_BITS > 15) begin : bad_addr_bits
        $error("ADDR_BITS must be 14 or 15");
    end
    if (WRITE_CYCLE_COUNT < 1) begin : bad_cycle_count
        $error("WRITE_CYCLE_COUNT must be at least 1");
    end

    // ---------------- link domain: reset and pin synchronisers
    logic       rst_meta;         // reset, first stage
    logic       link_reset;       // reset in link domain
    logic [2:0] pin_meta;         // scl, sda, inhibit first stage
    logic [2:0] pin_sync;         // second stage, safe to read
    logic [1:0] pin_last;         // scl and sda one cycle older
    logic       busy_meta;        // busy, first stage
    logic       busy_sync;        // busy seen in link domain

    // two flops on every level entering the link domain
    always_ff @(posedge link_clk) begin
        rst_meta   <= reset;
        link_reset <= rst_meta;
        pin_meta   <= {scl, sda_in, write_inhibit_n};
        pin_sync   <= pin_meta;
        pin_last   <= pin_sync[2:1];
        busy_meta  <= write_busy;
        busy_sync  <= busy_meta;
    end

    logic scl_s;       // synchronised clock line
    logic sda_s;       // synchronised data line
    logic wi_s;        // high inhibits writes
    logic scl_rise;    // clock low to high
    logic scl_fall;    // clock high to low
    logic start_seen;  // data falls, clock high
    logic stop_seen;   // data rises, clock high

    assign scl_s      = pin_sync[2];
    assign sda_s      = pin_sync[1];
    // an open pin is pulled low outside, so writes default to enabled
    assign wi_s       = pin_sync[0];
    assign scl_rise   = scl_s & ~pin_last[1];
    assign scl_fall   = ~scl_s & pin_last[1];
    assign start_seen = scl_s & pin_last[1] & pin_last[0] & ~sda_s;
    assign stop_seen  = scl_s & pin_last[1] & ~pin_last[0] & sda_s;

    // ---------------- link domain: storage
    logic [7:0]      mem [DEPTH];   // the byte array
    logic [7:0]      pbuf [PAGE];   // row latch filled by a write
    logic [PAGE-1:0] page_valid;    // row latch bytes to commit

    // ---------------- link domain: bus engine state
    bus_state_type            state, next_state;
    logic [3:0]               cnt, next_cnt;            // bit slot in byte
    logic [7:0]               shreg, next_shreg;        // shift in or out
    logic [7:0]               hi_byte, next_hi_byte;    // held high address
    logic [ADDR_BITS-1:0]     addr, next_addr;          // address counter
    logic                     drive, next_drive;        // pull data low
    logic                     inhibit, next_inhibit;    // write refused
    logic                     wrote, next_wrote;        // data byte latched
    logic                     after_ack, next_after_ack;// slot after an ack
    logic                     more, next_more;          // master acked read
    logic                     commit_tgl, next_commit_tgl; // write event
    logic                     wait_busy, next_wait_busy;   // busy not yet seen
    logic                     copy_active, next_copy_active;
    logic [PAGE_BITS-1:0]     copy_idx, next_copy_idx;  // byte being copied
    logic                     blocked;                  // ignore the bus
    logic                     pb_we;                    // latch a data byte
    logic                     pb_clear;                 // drop stale latch
    logic                     match;                    // select code hit
    logic [15:0]              full_addr;                // both address bytes

    // wait_busy covers the gap before the busy level crosses over
    assign blocked   = wait_busy | busy_sync | copy_active;
    assign match     = (shreg[7:4] == TYPE_ID)
                     & (shreg[3:1] == CHIP_ENABLE);
    assign full_addr = {hi_byte, shreg};
    assign pb_clear  = start_seen & ~blocked;

    // next values of the bus engine
    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_shreg      = shreg;
        next_hi_byte    = hi_byte;
        next_addr       = addr;
        next_drive      = drive;
        next_inhibit    = inhibit;
        next_wrote      = wrote;
        next_after_ack  = after_ack;
        next_more       = more;
        next_commit_tgl = commit_tgl;
        next_wait_busy  = wait_busy;
        pb_we           = 1'b0;
        if (wait_busy && busy_sync) begin
            next_wait_busy = 1'b0;
        end
        if (blocked) begin
            // busy: data input disabled, no answer at all
            next_state     = ST_IDLE;
            next_drive     = 1'b0;
            next_after_ack = 1'b0;
        end else if (start_seen) begin
            // start or repeated start; inhibit sampled from here on
            // a repeated start keeps the address of a dummy write
            next_state     = ST_SELECT;
            next_cnt       = CNT_ZERO;
            next_drive     = 1'b0;
            next_after_ack = 1'b0;
            next_inhibit   = wi_s;
            next_wrote     = 1'b0;
        end else if (stop_seen) begin
            // only a stop right after a data ack launches the cycle
            if (after_ack && state == ST_WDATA && wrote) begin
                next_commit_tgl = ~commit_tgl;
                next_wait_busy  = 1'b1;
            end
            next_state     = ST_IDLE;
            next_drive     = 1'b0;
            next_after_ack = 1'b0;
        end else begin
            // inhibit window closes after the second address byte
            if (wi_s && (state == ST_SELECT || state == ST_ADDR_HI
                         || state == ST_ADDR_LO)) begin
                next_inhibit = 1'b1;
            end
            case (state)
                ST_IDLE, ST_HOLD: begin
                    // released until start or stop
                    next_drive = 1'b0;
                end
                ST_RDATA: begin
                    // reads never look at inhibit
                    if (scl_rise) begin
                        if (cnt == ACK_SLOT) begin
                            next_more = ~sda_s;
                        end else begin
                            next_cnt = cnt + CNT_ONE;
                        end
                    end else if (scl_fall) begin
                        if (cnt == BYTE_DONE) begin
                            // release for the master's ack, count the byte
                            next_drive = 1'b0;
                            next_addr  = addr + 1'b1;
                            next_cnt   = ACK_SLOT;
                        end else if (cnt == ACK_SLOT) begin
                            if (more) begin
                                next_shreg = mem[addr];
                                next_drive = ~mem[addr][7];
                                next_cnt   = CNT_ZERO;
                            end else begin
                                next_state = ST_HOLD;
                                next_drive = 1'b0;
                            end
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive = ~shreg[6];
                        end
                    end
                end
                default: begin
                    // receiving select, address or data bytes
                    // after_ack must live through the stop's own clock high
                    if (scl_rise) begin
                        if (cnt != ACK_SLOT) begin
                            next_shreg = {shreg[6:0], sda_s};
                            next_cnt   = cnt + CNT_ONE;
                        end
                    end else if (scl_fall && cnt == BYTE_DONE) begin
                        // byte complete: decide the ninth slot
                        next_cnt   = ACK_SLOT;
                        next_drive = 1'b1;
                        case (state)
                            ST_SELECT: begin
                                if (!match) begin
                                    next_state = ST_IDLE;
                                    next_drive = 1'b0;
                                end
                            end
                            ST_ADDR_HI: begin
                                next_hi_byte = shreg;
                            end
                            ST_ADDR_LO: begin
                                // top bits dropped by width
                                next_addr = full_addr[ADDR_BITS-1:0];
                            end
                            default: begin
                                if (inhibit) begin
                                    next_drive = 1'b0;
                                end else begin
                                    pb_we      = 1'b1;
                                    next_wrote = 1'b1;
                                    // roll over inside the row
                                    next_addr[PAGE_BITS-1:0] =
                                        addr[PAGE_BITS-1:0] + 1'b1;
                                end
                            end
                        endcase
                    end else if (scl_fall && cnt == ACK_SLOT) begin
                        // end of ninth slot: release and move on
                        next_drive     = 1'b0;
                        next_cnt       = CNT_ZERO;
                        next_after_ack = drive;
                        case (state)
                            ST_SELECT: begin
                                if (shreg[0]) begin
                                    next_state = ST_RDATA;
                                    next_shreg = mem[addr];
                                    next_drive = ~mem[addr][7];
                                end else begin
                                    next_state = ST_ADDR_HI;
                                end
                            end
                            ST_ADDR_HI: next_state = ST_ADDR_LO;
                            ST_ADDR_LO: next_state = ST_WDATA;
                            default:    next_state = state;
                        endcase
                    end else if (scl_fall) begin
                        // slot after the ack ended without a stop
                        next_after_ack = 1'b0;
                    end
                end
            endcase
        end
    end

    // next values of the row copy into the array
    always_comb begin
        next_copy_active = copy_active;
        next_copy_idx    = copy_idx;
        if (commit_tgl != next_commit_tgl) begin
            next_copy_active = 1'b1;
            next_copy_idx    = '0;
        end else if (copy_active) begin
            next_copy_idx = copy_idx + 1'b1;
            if (&copy_idx) begin
                next_copy_active = 1'b0;
            end
        end
    end

    // register the link-domain control state
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            state       <= ST_IDLE;
            cnt         <= CNT_ZERO;
            shreg       <= 8'h00;
            hi_byte     <= 8'h00;
            addr        <= '0;
            drive       <= 1'b0;
            inhibit     <= 1'b0;
            wrote       <= 1'b0;
            after_ack   <= 1'b0;
            more        <= 1'b0;
            commit_tgl  <= 1'b0;
            wait_busy   <= 1'b0;
            copy_active <= 1'b0;
            copy_idx    <= '0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            shreg       <= next_shreg;
            hi_byte     <= next_hi_byte;
            addr        <= next_addr;
            drive       <= next_drive;
            inhibit     <= next_inhibit;
            wrote       <= next_wrote;
            after_ack   <= next_after_ack;
            more        <= next_more;
            commit_tgl  <= next_commit_tgl;
            wait_busy   <= next_wait_busy;
            copy_active <= next_copy_active;
            copy_idx    <= next_copy_idx;
        end
    end

    // row latch and array; array contents are not reset
    always_ff @(posedge link_clk) begin
        if (link_reset || pb_clear) begin
            page_valid <= '0;
        end else if (pb_we) begin
            page_valid[addr[PAGE_BITS-1:0]] <= 1'b1;
        end else if (copy_active) begin
            page_valid[copy_idx] <= 1'b0;
        end
        if (pb_we) begin
            pbuf[addr[PAGE_BITS-1:0]] <= shreg;
        end
        // the row part of addr cannot move while copying
        if (copy_active && page_valid[copy_idx]) begin
            mem[{addr[ADDR_BITS-1:PAGE_BITS], copy_idx}] <= pbuf[copy_idx];
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive;

    // ---------------- core domain: self-timed write cycle
    logic        c_meta;               // commit toggle, first stage
    logic        c_sync;               // commit toggle, safe
    logic        c_last;               // previous safe value
    logic [31:0] timer, next_timer;    // cycles left in the write
    logic        next_busy;

    // toggle crossing of the commit event
    always_ff @(posedge clk) begin
        c_meta <= commit_tgl;
        c_sync <= c_meta;
        c_last <= c_sync;
    end

    // next values of the write timer
    always_comb begin
        next_timer = timer;
        if (c_sync != c_last) begin
            next_timer = 32'(WRITE_CYCLE_COUNT);
        end else if (timer != 32'h0) begin
            next_timer = timer - 32'h1;
        end
        next_busy = (next_timer != 32'h0);
    end

    // register the timer and the busy flag
    always_ff @(posedge clk) begin
        if (reset) begin
            timer      <= 32'h0;
            write_busy <= 1'b0;
        end else begin
            timer      <= next_timer;
            write_busy <= next_busy;
        end
    end
endmodule

// *** eeprom_slave_sva.sv ***
// port-level assertion checker for the serial memory slave
`timescale 1ns/1ps
module eeprom_slave_sva #(
    parameter int WRITE_CYCLE_COUNT = 200
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_inhibit_n,
    input wire logic write_busy
);
    logic [31:0] busy_cnt;       // core cycles seen busy so far
    logic [31:0] next_busy_cnt;  // next value of the busy count
    // count the busy run, clear as soon as it ends
    always_comb begin
        next_busy_cnt = write_busy ? busy_cnt + 32'h1 : 32'h0;
    end
    // register the count; reset keeps it in step with the device
    always_ff @(posedge clk) begin
        busy_cnt <= reset ? 32'h0 : next_busy_cnt;
    end
    a_open_drain_low: assert property (@(posedge link_clk) disable iff (reset)
        sda_out == 1'b0) else $error("data output level not low");
    a_oe_after_fall: assert property (@(posedge link_clk) disable iff (reset)
        $changed(sda_oe) |-> !scl && !$past(scl)) else $error("data drive moved near clock high");
    a_oe_steady_high: assert property (@(posedge link_clk) disable iff (reset)
        scl && $past(scl) |-> $stable(sda_oe)) else $error("data drive moved while clock high");
    a_oe_bounded: assert property (@(posedge link_clk) disable iff (reset)
        $rose(sda_oe) |-> ##[1:1000] !sda_oe) else $error("data line held too long");
    a_busy_quiet: assert property (@(posedge clk) disable iff (reset)
        write_busy |-> !sda_oe) else $error("device answered while busy");
    a_busy_hold: assert property (@(posedge clk) disable iff (reset)
        $rose(write_busy) |=> write_busy [*8]) else $error("write cycle ended early");
    a_busy_length: assert property (@(posedge clk) disable iff (reset)
        $fell(write_busy) |-> busy_cnt == 32'(WRITE_CYCLE_COUNT))
        else $error("write cycle length wrong");
    a_busy_bus_idle: assert property (@(posedge clk) disable iff (reset)
        $rose(write_busy) |-> scl && sda_in) else $error("write cycle began without stop");
endmodule
bind serial_eeprom_i2c_slave eeprom_slave_sva #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) u_sva (
    .clk(clk), .reset(reset), .link_clk(link_clk), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_inhibit_n(write_inhibit_n),
    .write_busy(write_busy));

// *** bus_master.sv ***
// two-wire bus master model: drives the serial clock and its side of the data line
`timescale 1ns/1ps
module bus_master (
    output logic      scl,
    output wire logic sda_line,
    input  wire logic sda_out,
    input  wire logic sda_oe
);
    logic m_sda;  // master data drive, 1 means released
    // open drain wire: pull-up unless either side pulls low
    assign sda_line = (sda_oe ? sda_out : 1'b1) & m_sda;
    // bus idles with both lines high; clock stands still between frames
    initial begin
        scl = 1'b1;
        m_sda = 1'b1;
    end
    // one bit slot: data moves only in the low phase, sampled mid high phase
    task automatic slot(input logic b, output logic seen);
        #200 m_sda = b;
        #200 scl = 1'b1;
        #200 seen = sda_line;
        #200 scl = 1'b0;
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        #200 m_sda = 1'b1;
        #200 scl = 1'b1;
        #400 m_sda = 1'b0;
        #400 scl = 1'b0;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        #200 m_sda = 1'b0;
        #200 scl = 1'b1;
        #400 m_sda = 1'b1;
        #400;
    endtask
    // send a byte msb first, then release and read the acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) slot(b[i], d);
        slot(1'b1, d);
        ack = ~d;
    endtask
    // read a byte; acknowledge only if more bytes are wanted
    task automatic rbyte(input logic more, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
        slot(~more, d);
    endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
module testbench;
    import serial_eeprom_pkg::*;
    localparam int         WCC     = 200;  // shortened write cycle, core cycles
    localparam logic [7:0] PD [4]  = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};  // page data
    logic       clk;              // core clock
    logic       reset;            // synchronous reset
    logic       link_clk;         // bus sampling clock
    logic       scl;              // serial clock from the master model
    wire logic  sda_in;           // resolved data wire
    logic       sda_out;          // device data level
    logic       sda_oe;           // device pulls data low
    logic       write_inhibit_n;  // high blocks writes
    logic       write_busy;       // write cycle running
    int         errors;           // mismatches
    int         n_compared;       // comparisons made
    int         cycles;           // watchdog count
    int         polls;            // polls while busy
    logic [7:0] sel;              // select byte, write direction
    logic [7:0] rd;               // byte read back
    logic       ack;              // acknowledge seen by master

    serial_eeprom_i2c_slave #(.WRITE_CYCLE_COUNT(WCC)) dut (
        .clk(clk), .reset(reset), .link_clk(link_clk), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_inhibit_n(write_inhibit_n),
        .write_busy(write_busy));
    bus_master u_bus (.scl(scl), .sda_line(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

    // core clock 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // link clock 12 ns, offset so it never lines up with the core clock
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // watchdog: a hung handshake must not stall the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("[FAIL] %0t watchdog expired", $time);
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    // start, select and both address bytes, each one acknowledged
    task automatic addr_phase(input logic [15:0] a);
        logic [7:0] b [3];
        b = '{sel, a[15:8], a[7:0]};
        u_bus.start();
        for (int i = 0; i < 3; i++) begin
            u_bus.wbyte(b[i], ack);
            check({7'h00, ack}, 8'h01, "header ack");
        end
    endtask
    // dummy write, then restart with the same code in read direction
    task automatic read_at(input logic [15:0] a);
        addr_phase(a);
        u_bus.start();
        u_bus.wbyte(sel | 8'h01, ack);
        check({7'h00, ack}, 8'h01, "read select ack");
    endtask
    task automatic get(input logic more, input logic [7:0] exp);
        u_bus.rbyte(more, rd);
        check(rd, exp, "read data");
    endtask
    // wait a bounded time for the write cycle to start, or confirm it never does
    task automatic busy_after(input logic exp);
        for (int i = 0; i < 20 && write_busy !== 1'b1; i++) @(negedge clk);
        check({7'h00, write_busy}, {7'h00, exp}, "write cycle start");
    endtask
    // page write across the row end, busy polling, then every read kind
    task automatic t_page_write();
        addr_phase(16'h013e);
        for (int i = 0; i < 4; i++) begin
            u_bus.wbyte(PD[i], ack);
            check({7'h00, ack}, 8'h01, "data ack");
        end
        u_bus.stop();
        busy_after(1'b1);
        polls = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && polls < 100) begin
            u_bus.start();
            u_bus.wbyte(sel, ack);
            if (polls == 0) check({7'h00, ack}, 8'h00, "busy poll");
            polls++;
        end
        check({7'h00, ack}, 8'h01, "poll acknowledged");
        u_bus.wbyte(8'h01, ack);
        u_bus.wbyte(8'h3e, ack);
        u_bus.start();
        u_bus.wbyte(sel | 8'h01, ack);
        get(1'b0, PD[0]);
        u_bus.stop();
        u_bus.start();
        u_bus.wbyte(sel | 8'h01, ack);
        get(1'b0, PD[1]);
        u_bus.stop();
        read_at(16'h8100);
        get(1'b1, PD[2]);
        get(1'b0, PD[3]);
        u_bus.stop();
        $display("page write and reads done");
    endtask
    // foreign type code and nonzero chip enable both go unanswered
    task automatic t_select_miss();
        logic [7:0] bad [2];
        bad = '{{TYPE_ID_DEFAULT ^ 4'h1, CHIP_ENABLE, 1'b1}, {TYPE_ID_DEFAULT, 3'h4, 1'b1}};
        for (int i = 0; i < 2; i++) begin
            u_bus.start();
            u_bus.wbyte(bad[i], ack);
            check({7'h00, ack}, 8'h00, "foreign select");
            u_bus.stop();
        end
        $display("select mismatch done");
    endtask
    // inhibited write, read under inhibit, stop with no data byte
    task automatic t_inhibit();
        @(negedge clk) write_inhibit_n = 1'b1;
        addr_phase(16'h013e);
        u_bus.wbyte(8'h5a, ack);
        check({7'h00, ack}, 8'h00, "inhibited data");
        u_bus.stop();
        busy_after(1'b0);
        read_at(16'h013e);
        get(1'b0, PD[0]);
        u_bus.stop();
        @(negedge clk) write_inhibit_n = 1'b0;
        addr_phase(16'h013f);
        u_bus.stop();
        busy_after(1'b0);
        // acked data byte, then a stop one bit late: no write cycle
        addr_phase(16'h013f);
        u_bus.wbyte(8'h77, ack);
        check({7'h00, ack}, 8'h01, "late stop data ack");
        u_bus.slot(1'b0, ack);
        u_bus.stop();
        busy_after(1'b0);
        read_at(16'h013f);
        get(1'b0, PD[1]);
        u_bus.stop();
        $display("write inhibit done");
    endtask
    // main sequence: 20 cycles of reset, margin for the link domain, then tests
    initial begin
        errors = 0;
        n_compared = 0;
        cycles = 0;
        reset = 1'b1;
        write_inhibit_n = 1'b0;
        sel = {TYPE_ID_DEFAULT, CHIP_ENABLE, 1'b0};
        repeat (20) @(negedge clk);
        reset = 1'b0;
        #1000;
        t_select_miss();
        t_page_write();
        t_inhibit();
        wrap_up();
    end
endmodule
